// *** src/dsb_defs.vh ***
/*
  Field positions, reset values and timing of the debug status/control
  byte and the breakpoint match register.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DSB_DEFS_VH
`define DSB_DEFS_VH

// Status/control byte fields
`define DSB_BIT_PERMIT      3'd7
`define DSB_BIT_ACTIVE      3'd6
`define DSB_BIT_BKPT_EN     3'd5
`define DSB_BIT_FORCE_TAG   3'd4
`define DSB_BIT_CLK_SEL     3'd3
`define DSB_BIT_WAIT_STOP   3'd2
`define DSB_BIT_WS_FAIL     3'd1
`define DSB_BIT_DV_FAIL     3'd0

// Reset values
`define DSB_CTRL_RESET      8'h00
`define DSB_BKPT_RESET      16'h0000

// Widths
`define DSB_CTRL_W          8
`define DSB_ADDR_W          16

// Timing: answer latency of a register read command
`define DSB_READ_LAT_NS     4
`define DSB_CLK_PERIOD_NS   4
`define DSB_READ_LAT_CYC    (`DSB_READ_LAT_NS / `DSB_CLK_PERIOD_NS)

`endif

// *** src/dsb_sync2.v ***
/*
  Two-flop level synchroniser.
  Assumes the input is a level from a foreign or gated clock domain.
*/
`timescale 1ns/1ps
`include "dsb_defs.vh"

module dsb_sync2
(
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Level in and out
  input  wire async_in,
  output reg  sync_out
);

  reg meta;

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // dsb_sync2

// *** src/dsb_bkpt_compare.v ***
/*
  Breakpoint address comparator.
  Assumes cpu_addr is valid whenever cpu_bus_cycle is high.
*/
`timescale 1ns/1ps
`include "dsb_defs.vh"

module dsb_bkpt_compare
#(
  parameter ADDR_W = `DSB_ADDR_W
)
(
  // Configuration
  input  wire              enable,
  input  wire [ADDR_W-1:0] match_addr,
  // CPU bus
  input  wire              cpu_bus_cycle,
  input  wire [ADDR_W-1:0] cpu_addr,
  // Result
  output wire              hit
);

  // Full-width compare on every bus cycle while enabled
  assign hit = enable & cpu_bus_cycle & (cpu_addr == match_addr);

endmodule // dsb_bkpt_compare

// *** src/dsb_status_ctrl.v ***
/*
  Debug status/control byte and hardware breakpoint match register of a
  single-wire background debug controller, with the breakpoint request
  logic toward the CPU.
  Assumes a command decoder on clk_sys that issues one-cycle command
  strobes, and a CPU that reports instruction boundaries, tagged opcodes
  reaching the end of its queue and its wait/stop state (from a gated
  low-power domain, hence synchronised).
*/
//
// Overview of operation
// - Status/control byte reached only by status-read and control-write commands.
// - Permit bit gates entry to halt mode; reset clears it, a control write outside halt mode loads it from bit 7.
// - Active flag is read-only, 1 only while halted awaiting commands.
// - Breakpoint enable clear disables the match, ignoring select and address.
// - Force select: address match halts at next instruction boundary.
// - Tag select: match tags the fetched opcode; halt if it executes.
// - Clock select resets to 0 (alternate clock); 1 selects bus clock.
// - In wait/stop memory access commands fail; background command still halts.
// - Wait/stop flag is 1 in wait/stop or after halting from it.
// - Wait/stop failure flag set when memory access collides with wait/stop.
// - Data-valid failure flag always reads 0 on this device.
// - Breakpoint register is 16 bits, reached only by its own commands.
// - Writes to the permit bit are ignored while halted.
// - The four status flags are never changed by the control write.
// - Breakpoint with permit clear raises a software interrupt instead.
`timescale 1ns/1ps
`include "dsb_defs.vh"

module dsb_status_ctrl
#(
  parameter ADDR_W = `DSB_ADDR_W
)
(
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst,
  // Serial command strobes from the command decoder
  input  wire              cmd_read_status,
  input  wire              cmd_write_control,
  input  wire [7:0]        cmd_ctrl_wdata,
  input  wire              cmd_breakpoint_read_command,
  input  wire              cmd_breakpoint_write_command,
  input  wire [ADDR_W-1:0] cmd_bkpt_wdata,
  input  wire              cmd_background,
  input  wire              cmd_go,
  input  wire              cmd_mem_access,
  // Register read answers
  output reg  [7:0]        status_rdata,
  output reg  [ADDR_W-1:0] bkpt_rdata,
  output reg               rdata_valid,
  // Command gating toward the decoder
  output wire              mem_access_ok,
  output reg               mem_access_fail,
  output wire              halt_cmds_allowed,
  // CPU interface
  input  wire              cpu_bus_cycle,
  input  wire [ADDR_W-1:0] cpu_addr,
  input  wire              cpu_opcode_fetch,
  input  wire              cpu_instr_boundary,
  input  wire              cpu_tag_at_end,
  input  wire              cpu_wait_stop,
  output wire              tag_opcode,
  output reg               enter_halt,
  output reg               swi_request,
  output wire              cpu_halted,
  // Communication clock choice
  output wire              comm_clock_select
);

  // Sequencer states
  localparam ST_RUN    = 2'b00;
  localparam ST_FORCE  = 2'b01;
  localparam ST_HALTED = 2'b10;

  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg               background_permit_bit;
  reg               hw_breakpoint_enable;
  reg               force_tag_select;
  reg               comm_clk_sel;
  reg               halted_from_ws;
  reg               wait_stop_failure_flag;
  reg  [ADDR_W-1:0] breakpoint_match_address;
  reg               next_enter;
  reg               next_swi;
  wire              wait_stop_sync;
  wire              bkpt_hit;
  wire              background_active_flag;
  wire              wait_stop_flag;
  wire              data_valid_failure_flag;
  wire              force_hit;
  wire              halt_event;
  wire              cmd_blocked;
  reg  [7:0]        status_byte;

  // CPU low-power state comes from a gated domain
  // Two edges late; a halt in that gap misses the sticky wait/stop part
  dsb_sync2 u_ws_sync
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (cpu_wait_stop),
    .sync_out (wait_stop_sync)
  );

  // Hit is combinational so a tag lands on the same fetch cycle
  dsb_bkpt_compare #(.ADDR_W(ADDR_W)) u_cmp
  (
    .enable        (hw_breakpoint_enable),
    .match_addr    (breakpoint_match_address),
    .cpu_bus_cycle (cpu_bus_cycle),
    .cpu_addr      (cpu_addr),
    .hit           (bkpt_hit)
  );

  assign background_active_flag = (state == ST_HALTED);
  assign cpu_halted             = background_active_flag;
  assign wait_stop_flag = wait_stop_sync | halted_from_ws;
  // No slow memory, so this can never fail
  assign data_valid_failure_flag = 1'b0;
  assign comm_clock_select = comm_clk_sel;

  // Tag only on opcode fetches; force handled by the sequencer
  assign tag_opcode = bkpt_hit & ~force_tag_select
                      & cpu_opcode_fetch;
  assign force_hit  = bkpt_hit & force_tag_select;

  // Memory access commands are dead during wait/stop; once
  // halted the CPU has left it, so they work again
  assign cmd_blocked       = wait_stop_sync & ~background_active_flag;
  assign mem_access_ok     = ~cmd_blocked;
  assign halt_cmds_allowed = background_active_flag;

  // Placed by field position so the bit map lives in the header
  always @*
  begin
    status_byte                     = `DSB_CTRL_RESET;
    status_byte[`DSB_BIT_PERMIT]    = background_permit_bit;
    status_byte[`DSB_BIT_ACTIVE]    = background_active_flag;
    status_byte[`DSB_BIT_BKPT_EN]   = hw_breakpoint_enable;
    status_byte[`DSB_BIT_FORCE_TAG] = force_tag_select;
    status_byte[`DSB_BIT_CLK_SEL]   = comm_clk_sel;
    status_byte[`DSB_BIT_WAIT_STOP] = wait_stop_flag;
    status_byte[`DSB_BIT_WS_FAIL]   = wait_stop_failure_flag;
    status_byte[`DSB_BIT_DV_FAIL]   = data_valid_failure_flag;
  end

  // Control write; status bits are not stored from the write data
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      background_permit_bit <= 1'b0;
      hw_breakpoint_enable  <= 1'b0;
      force_tag_select      <= 1'b0;
      comm_clk_sel          <= 1'b0;
    end
    else if (cmd_write_control)
    begin
      // Would otherwise forbid the mode we are already in
      if (!background_active_flag)
        background_permit_bit <=
          cmd_ctrl_wdata[`DSB_BIT_PERMIT];
      hw_breakpoint_enable <= cmd_ctrl_wdata[`DSB_BIT_BKPT_EN];
      force_tag_select     <= cmd_ctrl_wdata[`DSB_BIT_FORCE_TAG];
      comm_clk_sel         <= cmd_ctrl_wdata[`DSB_BIT_CLK_SEL];
      // Flag bits of the write data are dropped here
    end
  end

  // Breakpoint match register, own commands only
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      breakpoint_match_address <= `DSB_BKPT_RESET;
    else if (cmd_breakpoint_write_command)
      breakpoint_match_address <= cmd_bkpt_wdata;
  end

  // Read answers, registered
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      status_rdata <= `DSB_CTRL_RESET;
      bkpt_rdata   <= `DSB_BKPT_RESET;
      rdata_valid  <= 1'b0;
    end
    else
    begin
      rdata_valid <= cmd_read_status | cmd_breakpoint_read_command;
      if (cmd_read_status)
        status_rdata <= status_byte;
      if (cmd_breakpoint_read_command)
        bkpt_rdata <= breakpoint_match_address;
    end
  end

  // Memory access collision with wait/stop; the set wins over the clear
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wait_stop_failure_flag <= 1'b0;
      mem_access_fail        <= 1'b0;
    end
    else
    begin
      mem_access_fail <= cmd_mem_access & cmd_blocked;
      if (cmd_mem_access & cmd_blocked)
        wait_stop_failure_flag <= 1'b1;
      else if (cmd_mem_access)
        wait_stop_failure_flag <= 1'b0;
    end
  end

  // A halt request from either a tagged opcode or a forced match
  assign halt_event = cpu_tag_at_end
                      | (state == ST_FORCE & cpu_instr_boundary);

  always @*
  begin
    next_state = state;
    next_enter = 1'b0;
    next_swi   = 1'b0;
    case (state)
      ST_RUN:
      begin
        if (cmd_background & background_permit_bit)
        begin
          next_state = ST_HALTED;
          next_enter = 1'b1;
        end
        else if (cpu_tag_at_end)
        begin
          if (background_permit_bit)
          begin
            next_state = ST_HALTED;
            next_enter = 1'b1;
          end
          else
            next_swi = 1'b1;
        end
        else if (force_hit)
          next_state = ST_FORCE;
      end
      ST_FORCE:
      begin
        // Wait for the current instruction to finish before halting
        if (cmd_background & background_permit_bit)
        begin
          next_state = ST_HALTED;
          next_enter = 1'b1;
        end
        else if (halt_event)
        begin
          if (background_permit_bit)
          begin
            next_state = ST_HALTED;
            next_enter = 1'b1;
          end
          else
          begin
            next_state = ST_RUN;
            next_swi   = 1'b1;
          end
        end
      end
      ST_HALTED:
      begin
        // A second background command is ignored; only resume leaves
        if (cmd_go)
          next_state = ST_RUN;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state          <= ST_RUN;
      enter_halt     <= 1'b0;
      swi_request    <= 1'b0;
      halted_from_ws <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      enter_halt  <= next_enter;
      swi_request <= next_swi;
      // Remember a halt taken out of wait/stop until resumed
      if (next_enter & wait_stop_sync)
        halted_from_ws <= 1'b1;
      else if (state == ST_HALTED & cmd_go)
        halted_from_ws <= 1'b0;
    end
  end

endmodule // dsb_status_ctrl

// *** verification/dsb_chk.sv ***
/*
  Port checker of the debug status/control block.
  Assumes a bind onto dsb_status_ctrl, one clock domain on clk_sys.
*/
`timescale 1ns/1ps
module dsb_chk
(
  // Clock and reset
  input wire       clk_sys,
  input wire       rst,
  // Commands
  input wire       cmd_read_status,
  input wire       cmd_write_control,
  input wire       cmd_go,
  input wire       cmd_mem_access,
  input wire [7:0] cmd_ctrl_wdata,
  // CPU side
  input wire       cpu_wait_stop,
  input wire       cpu_opcode_fetch,
  // Answers
  input wire [7:0] status_rdata,
  input wire       rdata_valid,
  input wire       mem_access_ok,
  input wire       mem_access_fail,
  input wire       tag_opcode,
  input wire       halt_cmds_allowed,
  input wire       enter_halt,
  input wire       swi_request,
  input wire       cpu_halted,
  input wire       comm_clock_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  rd_answer_a: assert property (cmd_read_status |=> rdata_valid)
    else $error("status read got no answer");
  active_flag_a: assert property (cmd_read_status |=>
    status_rdata[6] == $past(cpu_halted)) else $error("active flag wrong");
  dv_zero_a: assert property (rdata_valid |-> !status_rdata[0])
    else $error("data-valid failure flag set");
  clk_sel_a: assert property (cmd_write_control |=>
    comm_clock_select == $past(cmd_ctrl_wdata[3])) else $error("clock sel");
  halt_hold_a: assert property (cpu_halted && !cmd_go |=> cpu_halted)
    else $error("halt dropped without resume");
  halt_gate_a: assert property (halt_cmds_allowed == cpu_halted &&
    (mem_access_ok || !cpu_halted)) else $error("halted but commands gated");
  ws_block_a: assert property (cpu_wait_stop [*3] ##0 !cpu_halted |->
    !mem_access_ok) else $error("access allowed in wait/stop");
  ws_fail_a: assert property (cmd_mem_access && !mem_access_ok |=>
    mem_access_fail) else $error("failed access not flagged");
  ws_okay_a: assert property (cmd_mem_access && mem_access_ok |=>
    !mem_access_fail) else $error("good access flagged");
  swi_run_a: assert property (swi_request |->
    !cpu_halted && !enter_halt) else $error("interrupt together with halt");
  tag_fetch_a: assert property (tag_opcode |-> cpu_opcode_fetch)
    else $error("tag without opcode fetch");
  halt_entry_a: assert property ($rose(cpu_halted) |-> enter_halt)
    else $error("halt without entry pulse");

  cover property (enter_halt);
  cover property (swi_request);
  cover property (mem_access_fail);
endmodule // dsb_chk

bind dsb_status_ctrl dsb_chk u_chk (.*);

// *** verification/dsb_host.sv ***
/*
  Debug host model: one-cycle command strobes with shared write data.
  Assumes the bench calls op and commands are sampled on clk_sys.
*/
`timescale 1ns/1ps
module dsb_host
(
  // Clock and answers
  input  wire         clk_sys,
  input  wire         rdata_valid,
  input  wire  [7:0]  status_rdata,
  input  wire  [15:0] bkpt_rdata,
  // Command strobes and data
  output wire         cmd_read_status,
  output wire         cmd_write_control,
  output wire         cmd_breakpoint_read_command,
  output wire         cmd_breakpoint_write_command,
  output wire         cmd_background,
  output wire         cmd_go,
  output wire         cmd_mem_access,
  output logic [15:0] dat
);
  logic [6:0] s = 7'h00;
  initial dat = 16'h5A5A;
  assign {cmd_mem_access, cmd_go, cmd_background, cmd_breakpoint_write_command,
          cmd_breakpoint_read_command, cmd_write_control, cmd_read_status} = s;

  task automatic op(input int k, input logic [15:0] d,
                    output logic [15:0] r, output logic v);
    @(posedge clk_sys);
    s[k] <= 1'b1;
    dat <= d;
    @(posedge clk_sys);
    s <= 7'h00;
    // Released data never shows the last value
    dat <= ~d;
    #1;
    v = rdata_valid;
    r = (k == 2) ? bkpt_rdata : {8'h00, status_rdata};
  endtask
endmodule // dsb_host

// *** verification/tb.sv ***
/*
  Self-checking bench of dsb_status_ctrl against an integer model.
  Assumes dsb_host and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, v, tg;
  logic cpu_bus_cycle = 1'b0, cpu_opcode_fetch = 1'b0, cpu_wait_stop = 1'b0;
  logic cpu_instr_boundary = 1'b0, cpu_tag_at_end = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, r;
  wire cmd_read_status, cmd_write_control, cmd_breakpoint_read_command, cmd_breakpoint_write_command;
  wire cmd_background, cmd_go, cmd_mem_access, rdata_valid, mem_access_ok;
  wire mem_access_fail, halt_cmds_allowed, tag_opcode, enter_halt;
  wire swi_request, cpu_halted, comm_clock_select;
  wire [7:0] status_rdata, cmd_ctrl_wdata;
  wire [15:0] bkpt_rdata, cmd_bkpt_wdata, dat;
  int fail_count = 0, compares = 0, seed = 32'h4d86df48;
  int pm = 0, bk = 0, ft = 0, ck = 0, hl = 0, ws = 0, wf = 0;
  logic [15:0] bp;
  assign cmd_ctrl_wdata = dat[7:0];
  assign cmd_bkpt_wdata = dat;
  always #2 clk_sys = ~clk_sys;
  dsb_status_ctrl DUT (.*);
  dsb_host h (.*);

  task automatic chk_rd(input logic [15:0] g, e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_fl(input logic g, e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rd_st();
    h.op(0, 16'h0000, r, v);
    chk_fl(v, 1'b1);
    chk_rd(r, {8'h00, pm[0], hl[0], bk[0], ft[0],
               ck[0], ws[0], wf[0], 1'b0});
  endtask
  task automatic wctl(input logic [15:0] d);
    h.op(1, d, r, v);
    if (hl == 0) pm = d[7];
    bk = d[5];
    ft = d[4];
    ck = d[3];
    chk_fl(comm_clock_select, ck[0]);
    rd_st();
  endtask
  // f = {bus cycle, opcode fetch, boundary, tag at end}
  task automatic cyc(input logic [3:0] f, input logic [15:0] a);
    @(posedge clk_sys);
    {cpu_bus_cycle, cpu_opcode_fetch, cpu_instr_boundary, cpu_tag_at_end} <= f;
    cpu_addr <= a;
    #1;
    tg = tag_opcode;
    @(posedge clk_sys);
    {cpu_bus_cycle, cpu_opcode_fetch, cpu_instr_boundary, cpu_tag_at_end}
      <= 4'h0;
    #1;
  endtask
  task automatic resume();
    h.op(5, 16'h0000, r, v);
    {hl, ws} = 0;
    chk_fl(cpu_halted, 1'b0);
  endtask
  task automatic conclude();
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #20000;
    fail_count++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd_st();
    h.op(2, 16'h0000, r, v);
    chk_rd(r, 16'h0000);
    repeat (3) wctl(16'($random(seed)));
    wctl(16'h0000);
    h.op(4, 16'h0000, r, v);
    chk_fl(cpu_halted, 1'b0);
    wctl(16'h0080);
    h.op(4, 16'h0000, r, v);
    chk_fl(enter_halt, 1'b1);
    hl = 1;
    rd_st();
    wctl(16'h0000);
    bp = 16'($random(seed));
    h.op(3, bp, r, v);
    h.op(2, 16'h0000, r, v);
    chk_rd(r, bp);
    wctl(16'h00B0);
    resume();
    cyc(4'h8, bp ^ 16'h8000);
    cyc(4'h2, 16'h0000);
    chk_fl(enter_halt, 1'b0);
    cyc(4'h8, bp);
    cyc(4'h2, 16'h0000);
    chk_fl(enter_halt, 1'b1);
    hl = 1;
    wctl(16'h00A0);
    resume();
    cyc(4'hC, bp);
    chk_fl(tg, 1'b1);
    cyc(4'h1, 16'h0000);
    chk_fl(cpu_halted, 1'b1);
    hl = 1;
    resume();
    wctl(16'h0080);
    cyc(4'hC, bp);
    chk_fl(tg, 1'b0);
    wctl(16'h0030);
    cyc(4'h8, bp);
    cyc(4'h2, 16'h0000);
    chk_fl(swi_request, 1'b1);
    wctl(16'h0080);
    @(posedge clk_sys);
    cpu_wait_stop <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ws = 1;
    h.op(6, 16'h0000, r, v);
    chk_fl(mem_access_fail, 1'b1);
    chk_fl(mem_access_ok, 1'b0);
    wf = 1;
    rd_st();
    h.op(4, 16'h0000, r, v);
    hl = 1;
    chk_fl(mem_access_ok, 1'b1);
    rd_st();
    @(posedge clk_sys);
    cpu_wait_stop <= 1'b0;
    repeat (3) @(posedge clk_sys);
    h.op(6, 16'h0000, r, v);
    chk_fl(mem_access_fail, 1'b0);
    wf = 0;
    resume();
    rd_st();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    {pm, bk, ft, ck, wf} = 0;
    rd_st();
    conclude();
  end
endmodule // tb
